// ==== inc/rrse_pkg.sv ====
// shared constants and types for the rotate/repeat/store execution block
package rrse_pkg;

    // apb byte offsets
    localparam logic [7:0] ADDR_CMD       = 8'h00;
    localparam logic [7:0] ADDR_OPND      = 8'h04;
    localparam logic [7:0] ADDR_FLAGS     = 8'h08;
    localparam logic [7:0] ADDR_LCOUNT    = 8'h0c;
    localparam logic [7:0] ADDR_LSTART    = 8'h10;
    localparam logic [7:0] ADDR_LLAST     = 8'h14;
    localparam logic [7:0] ADDR_PC        = 8'h18;
    localparam logic [7:0] ADDR_STATUS    = 8'h1c;
    localparam logic [7:0] ADDR_REG_BASE  = 8'h40;
    localparam logic [7:0] ADDR_MEM_BASE  = 8'h80;
    localparam logic [7:0] WINDOW_SPAN    = 8'h40;

    // flag word bit positions
    localparam int FLAG_C   = 0;
    localparam int FLAG_V   = 1;
    localparam int FLAG_Z   = 2;
    localparam int FLAG_N   = 3;
    localparam int FLAG_FU  = 4;
    localparam int FLAG_LO  = 5;
    localparam int FLAG_LU  = 6;
    localparam int FLAG_SAT = 7;
    localparam int FLAG_RPT = 8;
    localparam int FLAG_S   = 9;

    // status word bit positions
    localparam int STAT_BUSY    = 0;
    localparam int STAT_WAITING = 1;
    localparam int STAT_ILLEGAL = 2;
    localparam int STAT_PIN0    = 3;

    // reset values and limits
    localparam logic [31:0] FLAGS_RESET  = 32'h0000_0000;
    localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
    localparam logic [3:0]  EXT_REG_LAST = 4'h7;
    localparam int          IMM_WIDTH    = 16;

    // addressing selectors
    localparam logic [1:0] SEL_REG      = 2'h0;
    localparam logic [1:0] SEL_DIRECT   = 2'h1;
    localparam logic [1:0] SEL_INDIRECT = 2'h2;
    localparam logic [1:0] SEL_IMM      = 2'h3;

    // opcodes as software writes them
    typedef enum logic [3:0] {
        OP_NOP      = 4'h0,
        OP_ROT_R    = 4'h1,
        OP_ROT_RC   = 4'h2,
        OP_RPT_ONE  = 4'h3,
        OP_ILOCK    = 4'h4,
        OP_FSTORE   = 4'h5,
        OP_FSTORE_I = 4'h6,
        OP_ISTORE   = 4'h7,
        OP_ISTORE_I = 4'h8,
        OP_FSTORE_P = 4'h9,
        OP_ISTORE_P = 4'ha
    } rrse_op_type;

    // command word layout
    typedef struct packed {
        logic [9:0]  rsvd;
        logic [3:0]  idx_b;
        logic [3:0]  idx_a;
        logic [1:0]  mode;
        logic [3:0]  reg_b;
        logic [3:0]  reg_a;
        logic [3:0]  op;
    } rrse_cmd_type;

    typedef enum logic [1:0] {
        S_IDLE,
        S_EXEC,
        S_WAIT_ACK,
        S_REPEAT
    } rrse_state_type;

endpackage

// ==== verilog/rrse_core.sv ====
// execution unit for rotates, repeat-single, interlock signalling and stores
`timescale 1ns/1ps

module rrse_core
    import rrse_pkg::*;
#(
    parameter int REG_COUNT = 16,
    parameter int MEM_DEPTH = 16
)(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // apb slave
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // interlock flag pins
    input  wire logic        flag_pin_one_in,
    output logic             flag_pin_zero_out
);

    localparam int RIW = $clog2(REG_COUNT);
    localparam int MIW = $clog2(MEM_DEPTH);

    // the checks at the bottom share this clock and reset
    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    rrse_state_type state;
    rrse_cmd_type   fetched_opcode_latch;
    logic [31:0]    operand;
    logic [31:0]    flag_word;
    logic [31:0]    loop_count;
    logic [31:0]    loop_start_pointer;
    logic [31:0]    loop_last_pointer;
    logic [31:0]    pc;
    logic           illegal;
    logic [31:0]    regs [REG_COUNT];
    logic [31:0]    mem  [MEM_DEPTH];
    logic           ack_meta;
    logic           ack_sync;

    // apb decode
    logic        apb_done;
    logic        apb_wr;
    logic [7:0]  wr_off;
    logic        in_reg_win;
    logic        in_mem_win;
    logic        mapped;
    logic        cmd_write;
    logic [31:0] rd_word;

    // execution results
    logic              exec_fire;
    rrse_op_type       cur_op;
    logic              dst_ext;
    logic [31:0]       src_a;
    logic [31:0]       src_b;
    logic [MIW-1:0]    addr_one;
    logic [MIW-1:0]    addr_two;
    logic [31:0]       rpt_src;
    logic              next_rf_we;
    logic [31:0]       next_rf_data;
    logic              next_m1_we;
    logic [MIW-1:0]    next_m1_addr;
    logic [31:0]       next_m1_data;
    logic              next_m2_we;
    logic [MIW-1:0]    next_m2_addr;
    logic [31:0]       next_m2_data;
    logic [31:0]       next_flags;
    logic              next_rpt;
    logic              next_illegal;
    logic              loop_done;

    assign apb_done   = psel_in && penable_in && pready_out;
    assign apb_wr     = apb_done && pwrite_in;
    assign wr_off     = paddr_in - ADDR_REG_BASE;
    assign in_reg_win = (paddr_in >= ADDR_REG_BASE)
                     && (paddr_in < ADDR_REG_BASE + WINDOW_SPAN);
    assign in_mem_win = (paddr_in >= ADDR_MEM_BASE)
                     && (paddr_in < ADDR_MEM_BASE + WINDOW_SPAN);
    assign mapped     = in_reg_win || in_mem_win || (paddr_in <= ADDR_STATUS);
    assign cmd_write  = apb_wr && (paddr_in == ADDR_CMD)
                     && (state == S_IDLE);
    assign exec_fire  = (state == S_EXEC) || (state == S_REPEAT);
    assign cur_op     = rrse_op_type'(fetched_opcode_latch.op);
    assign loop_done  = (state == S_REPEAT) && (loop_count == WORD_RESET);

    // acknowledge pin synchroniser; first stage feeds only the second
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ack_meta <= 1'b1;
            ack_sync <= 1'b1;
        end
        else
        begin
            ack_meta <= flag_pin_one_in;
            ack_sync <= ack_meta;
        end
    end

    // operand fetch and address formation
    always_comb
    begin
        dst_ext  = fetched_opcode_latch.reg_a <= EXT_REG_LAST;
        src_a    = regs[fetched_opcode_latch.reg_a[RIW-1:0]];
        src_b    = regs[fetched_opcode_latch.reg_b[RIW-1:0]];
        addr_two = regs[fetched_opcode_latch.idx_b[RIW-1:0]][MIW-1:0];
        if (fetched_opcode_latch.mode == SEL_DIRECT)
            addr_one = operand[MIW-1:0];
        else
            addr_one = regs[fetched_opcode_latch.idx_a[RIW-1:0]][MIW-1:0];
        case (fetched_opcode_latch.mode)
            SEL_REG:      rpt_src = src_a;
            SEL_DIRECT:   rpt_src = mem[addr_one];
            SEL_INDIRECT: rpt_src = mem[addr_one];
            default:      rpt_src = {{(32 - IMM_WIDTH){1'b0}},
                                     operand[IMM_WIDTH-1:0]};
        endcase
    end

    // one-cycle execution of the latched command; the overflow mode bit is
    // never consulted by any path below
    always_comb
    begin
        next_rf_we   = 1'b0;
        next_rf_data = src_a;
        next_m1_we   = 1'b0;
        next_m1_addr = addr_one;
        next_m1_data = src_a;
        next_m2_we   = 1'b0;
        next_m2_addr = addr_two;
        next_m2_data = src_b;
        next_flags   = flag_word;
        next_rpt     = 1'b0;
        next_illegal = 1'b0;
        if (exec_fire)
        begin
            case (cur_op)
                OP_ROT_R, OP_ROT_RC:
                begin
                    next_rf_we = 1'b1;
                    if (cur_op == OP_ROT_R)
                        next_rf_data = {src_a[0], src_a[31:1]};
                    else
                        next_rf_data = {flag_word[FLAG_C], src_a[31:1]};
                    if (dst_ext)
                    begin
                        next_flags[FLAG_C]  = src_a[0];
                        next_flags[FLAG_FU] = 1'b0;
                        next_flags[FLAG_V]  = 1'b0;
                        next_flags[FLAG_N]  = next_rf_data[31];
                        next_flags[FLAG_Z]  = next_rf_data == WORD_RESET;
                    end
                end
                OP_RPT_ONE:
                begin
                    next_rpt             = 1'b1;
                    next_flags[FLAG_RPT] = 1'b1;
                    next_flags[FLAG_S]   = 1'b1;
                end
                OP_FSTORE, OP_FSTORE_I, OP_ISTORE, OP_ISTORE_I:
                begin
                    // register and immediate destinations are refused
                    if (fetched_opcode_latch.mode == SEL_DIRECT
                        || fetched_opcode_latch.mode == SEL_INDIRECT)
                        next_m1_we = 1'b1;
                    else
                        next_illegal = 1'b1;
                end
                OP_FSTORE_P, OP_ISTORE_P:
                begin
                    next_m1_addr = regs[fetched_opcode_latch.idx_a[RIW-1:0]]
                                   [MIW-1:0];
                    next_m1_we   = 1'b1;
                    next_m2_we   = 1'b1;
                end
                default:
                begin
                    next_rf_we = 1'b0;
                end
            endcase
            if (loop_done)
            begin
                next_flags[FLAG_RPT] = 1'b0;
                next_flags[FLAG_S]   = 1'b0;
            end
        end
    end

    // sequencer
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state <= S_IDLE;
        else
        begin
            case (state)
                S_IDLE:
                    if (cmd_write)
                        state <= flag_word[FLAG_S] ? S_REPEAT : S_EXEC;
                S_EXEC:
                    state <= (cur_op == OP_ILOCK) ? S_WAIT_ACK : S_IDLE;
                S_WAIT_ACK:
                    if (!ack_sync)
                        state <= S_IDLE;
                S_REPEAT:
                    if (loop_done)
                        state <= S_IDLE;
                default:
                    state <= S_IDLE;
            endcase
        end
    end

    // command latch; during a repeat it alone supplies the opcode
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            fetched_opcode_latch <= '0;
        else if (cmd_write)
            fetched_opcode_latch <= rrse_cmd_type'(pwdata_in);
    end

    // interlock pin: low from request until the acknowledge arrives
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            flag_pin_zero_out <= 1'b1;
        else if (state == S_EXEC && cur_op == OP_ILOCK)
            flag_pin_zero_out <= 1'b0;
        else if (state == S_WAIT_ACK && !ack_sync)
            flag_pin_zero_out <= 1'b1;
        else if (exec_fire && (cur_op == OP_FSTORE_I
                               || cur_op == OP_ISTORE_I))
            flag_pin_zero_out <= 1'b1;
    end

    // flag word, software writes lose to execution in the same cycle
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            flag_word <= FLAGS_RESET;
        else if (exec_fire)
            flag_word <= next_flags;
        else if (apb_wr && paddr_in == ADDR_FLAGS)
            flag_word <= pwdata_in;
    end

    // loop registers and program counter
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            loop_count         <= WORD_RESET;
            loop_start_pointer <= WORD_RESET;
            loop_last_pointer  <= WORD_RESET;
            pc                 <= WORD_RESET;
        end
        else if (exec_fire && next_rpt)
        begin
            loop_count         <= rpt_src;
            loop_start_pointer <= pc + 32'h1;
            loop_last_pointer  <= pc + 32'h1;
            pc                 <= pc + 32'h1;
        end
        else if (state == S_REPEAT)
        begin
            // no fetch or branch cycle between passes
            loop_count <= loop_count - 32'h1;
            if (loop_done)
                pc <= loop_last_pointer + 32'h1;
        end
        else if (state == S_EXEC && cur_op != OP_ILOCK)
            pc <= pc + 32'h1;
        else if (state == S_WAIT_ACK && !ack_sync)
            pc <= pc + 32'h1;
        else if (apb_wr)
        begin
            if (paddr_in == ADDR_LCOUNT)
                loop_count <= pwdata_in;
            if (paddr_in == ADDR_LSTART)
                loop_start_pointer <= pwdata_in;
            if (paddr_in == ADDR_LLAST)
                loop_last_pointer <= pwdata_in;
            if (paddr_in == ADDR_PC)
                pc <= pwdata_in;
        end
    end

    // operand word and sticky illegal-mode flag
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            operand <= WORD_RESET;
            illegal <= 1'b0;
        end
        else
        begin
            if (apb_wr && paddr_in == ADDR_OPND)
                operand <= pwdata_in;
            // a new fault wins over the clear
            if (next_illegal)
                illegal <= 1'b1;
            else if (apb_wr && paddr_in == ADDR_STATUS
                     && pwdata_in[STAT_ILLEGAL])
                illegal <= 1'b0;
        end
    end

    // register file
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < REG_COUNT; i++)
                regs[i] <= WORD_RESET;
        end
        else if (next_rf_we)
            regs[fetched_opcode_latch.reg_a[RIW-1:0]] <= next_rf_data;
        else if (apb_wr && in_reg_win)
            regs[wr_off[RIW+1:2]] <= pwdata_in;
    end

    // data memory; second store written last so it wins a shared address
    always_ff @(posedge clk_in)
    begin
        if (next_m1_we)
            mem[next_m1_addr] <= next_m1_data;
        if (next_m2_we)
            mem[next_m2_addr] <= next_m2_data;
        if (!next_m1_we && !next_m2_we && apb_wr && in_mem_win)
            mem[paddr_in[MIW+1:2]] <= pwdata_in;
    end

    // read mux
    always_comb
    begin
        rd_word = WORD_RESET;
        if (in_reg_win)
            rd_word = regs[wr_off[RIW+1:2]];
        else if (in_mem_win)
            rd_word = mem[paddr_in[MIW+1:2]];
        else
        begin
            case (paddr_in)
                ADDR_CMD:     rd_word = fetched_opcode_latch;
                ADDR_OPND:    rd_word = operand;
                ADDR_FLAGS:   rd_word = flag_word;
                ADDR_LCOUNT:  rd_word = loop_count;
                ADDR_LSTART:  rd_word = loop_start_pointer;
                ADDR_LLAST:   rd_word = loop_last_pointer;
                ADDR_PC:      rd_word = pc;
                ADDR_STATUS:
                begin
                    rd_word[STAT_BUSY]    = state != S_IDLE;
                    rd_word[STAT_WAITING] = state == S_WAIT_ACK;
                    rd_word[STAT_ILLEGAL] = illegal;
                    rd_word[STAT_PIN0]    = flag_pin_zero_out;
                end
                default:      rd_word = WORD_RESET;
            endcase
        end
    end

    // apb answer: one wait cycle, all outputs registered
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pready_out  <= 1'b0;
            prdata_out  <= WORD_RESET;
            pslverr_out <= 1'b0;
        end
        else
        begin
            pready_out  <= psel_in && penable_in && !pready_out;
            prdata_out  <= pwrite_in ? WORD_RESET : rd_word;
            pslverr_out <= psel_in && penable_in && !pready_out
                        && (!mapped || (pwrite_in && paddr_in == ADDR_CMD
                                        && state != S_IDLE));
        end
    end

    // checks; clock and reset come from the defaults at the top
    rot_carry_a: assert property (
        exec_fire && cur_op == OP_ROT_R && dst_ext
        |=> flag_word[FLAG_C] == $past(src_a[0]))
        else $error("rotate carry wrong");
    rotc_value_a: assert property (
        exec_fire && cur_op == OP_ROT_RC |-> next_rf_data[31]
        == flag_word[FLAG_C] && next_rf_data[30:0] == src_a[31:1])
        else $error("rotate through carry wrong");
    flags_hold_a: assert property (
        exec_fire && (cur_op == OP_ROT_R || cur_op == OP_ROT_RC) && !dst_ext
        && !loop_done |=> $stable(flag_word))
        else $error("flags changed for plain register");
    rot_flags_a: assert property (
        exec_fire && cur_op == OP_ROT_R && dst_ext |=> !flag_word[FLAG_V]
        && !flag_word[FLAG_FU] && flag_word[FLAG_N]
        == $past(src_a[0]))
        else $error("rotate flags wrong");
    repeat_load_a: assert property (
        exec_fire && cur_op == OP_RPT_ONE |=> flag_word[FLAG_RPT]
        && flag_word[FLAG_S] && loop_start_pointer == pc
        && loop_last_pointer == pc)
        else $error("repeat setup wrong");
    ack_wait_a: assert property (
        state == S_WAIT_ACK && ack_sync |=> !flag_pin_zero_out
        && state == S_WAIT_ACK)
        else $error("interlock wait left early");
    ack_release_a: assert property (
        state == S_WAIT_ACK && !ack_sync |=> flag_pin_zero_out
        && state == S_IDLE)
        else $error("interlock not released");
    store_mode_a: assert property (
        exec_fire && cur_op == OP_ISTORE
        && fetched_opcode_latch.mode[0] == fetched_opcode_latch.mode[1]
        |-> !next_m1_we ##1 illegal)
        else $error("bad store destination accepted");
    par_order_a: assert property (
        exec_fire && (cur_op == OP_FSTORE_P || cur_op == OP_ISTORE_P)
        && next_m1_addr == next_m2_addr
        |=> mem[$past(next_m2_addr)] == $past(src_b))
        else $error("parallel store order wrong");
    exec_once_a: assert property (
        state == S_EXEC && cur_op != OP_ILOCK |=> state == S_IDLE)
        else $error("execution took extra cycle");
    cover_ilock_c: cover property (@(posedge clk_in)
        state == S_WAIT_ACK ##1 state == S_IDLE);
    cover_repeat_c: cover property (@(posedge clk_in)
        state == S_REPEAT ##1 state == S_REPEAT);
    cover_par_c: cover property (@(posedge clk_in)
        exec_fire && next_m2_we && next_m1_addr == next_m2_addr);

endmodule // rrse_core

// ==== dv/rrse_ack_model.sv ====
// far-side model that acknowledges interlocked operations
`timescale 1ns/1ps
module rrse_ack_model #(
    parameter int ACK_DELAY = 2
)(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    // interlock pins
    input  wire logic flag_pin_zero_in,
    output logic      flag_pin_one_out
);
    int wait_count;

    // ack only after a delay, so the design must really stall
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wait_count       <= 0;
            flag_pin_one_out <= 1'b1;
        end
        else if (flag_pin_zero_in)
        begin
            wait_count       <= 0;
            flag_pin_one_out <= 1'b1;
        end
        else if (wait_count >= ACK_DELAY)
            flag_pin_one_out <= 1'b0;
        else
            wait_count <= wait_count + 1;
    end
endmodule // rrse_ack_model

// ==== dv/rrse_core_tb_top.sv ====
// self-checking bench for the rotate/repeat/store execution unit
`timescale 1ns/1ps
module rrse_core_tb_top import rrse_pkg::*;;
    logic        clk_in     = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  paddr_in   = 8'h00;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [31:0] pwdata_in  = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        flag_pin_one_in;
    logic        flag_pin_zero_out;
    logic [31:0] rd;
    logic [31:0] pc;
    logic        err;
    int          n_errors    = 0;
    int          comparisons = 0;
    int          low_cycles  = 0;

    always #10 clk_in = ~clk_in;

    rrse_core i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .flag_pin_one_in(flag_pin_one_in),
        .flag_pin_zero_out(flag_pin_zero_out));
    rrse_ack_model i_ack (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .flag_pin_zero_in(flag_pin_zero_out),
        .flag_pin_one_out(flag_pin_one_in));

    // length of the interlock request seen on the pin
    always @(posedge clk_in)
        if (flag_pin_zero_out === 1'b0)
            low_cycles++;

    task automatic wrap_up;
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one apb transfer; an edge passes before the next may start
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        paddr_in  <= a;
        pwrite_in <= w;
        pwdata_in <= d;
        psel_in   <= 1'b1;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd  = prdata_out;
        err = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    function automatic logic [7:0] at(input logic [7:0] b, input int n);
        return b + 8'(n * 4);
    endfunction

    // start an operation and wait until busy and waiting drop
    task automatic cmd(input logic [3:0] op, input logic [3:0] ra,
        input logic [3:0] rb, input logic [1:0] md,
        input logic [3:0] ia, input logic [3:0] ib);
        rrse_cmd_type c;
        c = '{10'h0, ib, ia, md, rb, ra, op};
        apb(1'b1, ADDR_CMD, c);
        do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[1:0] !== 2'b00);
    endtask

    initial
    begin
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        apb(1'b1, at(ADDR_REG_BASE, 7), 32'h0000_0421);
        apb(1'b1, ADDR_FLAGS, 32'h92);
        cmd(OP_ROT_R, 4'h7, 4'h0, 2'h0, 4'h0, 4'h0);
        rchk("r7", at(ADDR_REG_BASE, 7), 32'h8000_0210);
        rchk("flags", ADDR_FLAGS, 32'h89);
        apb(1'b1, at(ADDR_REG_BASE, 4), 32'h8000_0080);
        cmd(OP_ROT_RC, 4'h4, 4'h0, 2'h0, 4'h0, 4'h0);
        rchk("r4", at(ADDR_REG_BASE, 4), 32'hc000_0040);
        rchk("flags", ADDR_FLAGS, 32'h88);
        apb(1'b1, ADDR_FLAGS, 32'h1);
        apb(1'b1, at(ADDR_REG_BASE, 8), 32'h8);
        apb(1'b1, at(ADDR_REG_BASE, 9), 32'h3);
        cmd(OP_ROT_RC, 4'h8, 4'h0, 2'h0, 4'h0, 4'h0);
        cmd(OP_ROT_R, 4'h9, 4'h0, 2'h0, 4'h0, 4'h0);
        rchk("r8", at(ADDR_REG_BASE, 8), 32'h8000_0004);
        rchk("r9", at(ADDR_REG_BASE, 9), 32'h8000_0001);
        rchk("flags", ADDR_FLAGS, 32'h1);
        // repeat three times from a register count
        apb(1'b1, at(ADDR_REG_BASE, 1), 32'h2);
        apb(1'b0, ADDR_PC, 32'h0);
        pc = rd + 32'h1;
        cmd(OP_RPT_ONE, 4'h1, 4'h0, SEL_REG, 4'h0, 4'h0);
        rchk("count", ADDR_LCOUNT, 32'h2);
        rchk("flags", ADDR_FLAGS, 32'h301);
        rchk("start", ADDR_LSTART, pc);
        rchk("last", ADDR_LLAST, pc);
        cmd(OP_ROT_RC, 4'h8, 4'h0, 2'h0, 4'h0, 4'h0);
        rchk("r8", at(ADDR_REG_BASE, 8), 32'hf000_0000);
        rchk("flags", ADDR_FLAGS, 32'h1);
        // integer store over all four destination selectors
        apb(1'b1, at(ADDR_REG_BASE, 2), 32'hfedc_ba98);
        apb(1'b1, at(ADDR_REG_BASE, 12), 32'h3);
        apb(1'b1, ADDR_OPND, 32'h3);
        for (int md = 0; md < 4; md++)
        begin
            apb(1'b1, at(ADDR_MEM_BASE, 3), 32'h0);
            cmd(OP_ISTORE, 4'h2, 4'h0, 2'(md), 4'hc, 4'h0);
            rchk("istore", at(ADDR_MEM_BASE, 3),
                 (md == 1 || md == 2) ? 32'hfedc_ba98 : 32'h0);
            rchk("illegal", ADDR_STATUS,
                 (md == 0 || md == 3) ? 32'hc : 32'h8);
            apb(1'b1, ADDR_STATUS, 32'h4);
        end
        cmd(OP_ILOCK, 4'h0, 4'h0, 2'h0, 4'h0, 4'h0);
        chk("pin0_low", 32'h1, 32'(low_cycles > 0));
        chk("pin0_idle", 32'h1, 32'(flag_pin_zero_out));
        // a command written during the interlock wait is refused
        apb(1'b1, ADDR_CMD, 32'(OP_ILOCK));
        apb(1'b1, ADDR_CMD, 32'(OP_NOP));
        chk("busy_err", 32'h1, 32'(err));
        do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[1:0] !== 2'b00);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, at(ADDR_MEM_BASE, 3), 32'h0);
            cmd(i == 0 ? OP_FSTORE : i == 1 ? OP_FSTORE_I : OP_ISTORE_I,
                4'h2, 4'h0, SEL_DIRECT, 4'h0, 4'h0);
            rchk("store", at(ADDR_MEM_BASE, 3), 32'hfedc_ba98);
            chk("pin0", 32'h1, 32'(flag_pin_zero_out));
        end
        // both halves of a parallel store to one word
        apb(1'b1, at(ADDR_REG_BASE, 3), 32'h1357_9bdf);
        apb(1'b1, at(ADDR_REG_BASE, 10), 32'h5);
        apb(1'b1, at(ADDR_REG_BASE, 11), 32'h5);
        cmd(OP_FSTORE_P, 4'h2, 4'h3, 2'h0, 4'ha, 4'hb);
        rchk("same", at(ADDR_MEM_BASE, 5), 32'h1357_9bdf);
        apb(1'b1, at(ADDR_REG_BASE, 11), 32'h6);
        cmd(OP_ISTORE_P, 4'h2, 4'h3, 2'h0, 4'ha, 4'hb);
        rchk("dst1", at(ADDR_MEM_BASE, 5), 32'hfedc_ba98);
        rchk("dst2", at(ADDR_MEM_BASE, 6), 32'h1357_9bdf);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        // immediate count with top bit set: no sign extension
        apb(1'b1, ADDR_OPND, 32'h8000);
        cmd(OP_RPT_ONE, 4'h0, 4'h0, SEL_IMM, 4'h0, 4'h0);
        rchk("imm", ADDR_LCOUNT, 32'h0000_8000);
        cmd(OP_ISTORE, 4'h3, 4'h0, SEL_DIRECT, 4'h0, 4'h0);
        rchk("flags", ADDR_FLAGS, 32'h1);
        wrap_up();
    end

    // the repeat of 32769 stores dominates the run time
    initial
    begin
        repeat (90000) @(posedge clk_in);
        n_errors++;
        wrap_up();
    end
endmodule // rrse_core_tb_top
